// >>> inc/icst_pkg.sv
// constants, register map and types of the internal clock settle and trim block
// assumes a 250 MHz aclk and an AXI4-Lite master with 32-bit data
package icst_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int BASE_HZ = 307_200;
    localparam int BASE_DIV = CLK_HZ / BASE_HZ;
    localparam logic [9:0] BASE_DIV_LAST = 10'(BASE_DIV - 1);
    localparam logic [1:0] CORR_TICKS_LAST = 2'h3;
    localparam logic [6:0] FINE_CORR_MAX = 7'h58;
    localparam logic [4:0] EXT_STAB_LAST = 5'h0F;
    localparam logic [11:0] COARSE_STEP = 12'h020;
    localparam logic [11:0] FINE_STEP = 12'h001;
    localparam logic [11:0] DCO_MAX = 12'h9FF;
    localparam logic [11:0] DCO_RESET = 12'h000;
    localparam logic [9:0] CAP_FIXED = 10'h180;
    localparam logic [7:0] TRIM_RESET = 8'h80;
    localparam logic [6:0] MULT_RESET = 7'h15;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_MULT = 8'h04;
    localparam logic [7:0] OFS_TRIM = 8'h08;
    localparam logic [7:0] OFS_DCO = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_OPTION = 8'h18;
    localparam int CTL_INTERNAL_CLOCK_OUT_ON = 0;
    localparam int CTL_ECLK_ON = 1;
    localparam int CTL_SRC_EXT = 2;
    localparam int CTL_MON_ON = 3;
    localparam int CTL_MON_IE = 4;
    localparam int CTL_INTERNAL_CLOCK_OUT_STABLE = 5;
    localparam int CTL_ECLK_STABLE = 6;
    localparam int CTL_MON_FAIL = 7;
    localparam int OPT_RUN_IN_STOP = 0;
    localparam int IRQ_W = 3;
    localparam int IRQ_STABLE = 0;
    localparam int IRQ_SETTLED = 1;
    localparam int IRQ_MON_FAIL = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {LF_HALT, LF_COARSE, LF_FINE, LF_DONE} icst_lf_type;

    typedef struct packed {
        logic [3:0] divider;
        logic [7:0] stage;
    } icst_dco_type;

    typedef struct packed {
        logic internal;
        logic selected;
        logic bus;
        logic timebase;
    } icst_clocks_type;
endpackage

// >>> verilog/icst_top.sv
// internal clock generator control: loop filter, trim, low-power modes, AXI4-Lite registers
// assumes synchronous inputs on aclk; the analog comparator reports error sign and 15% window
// Operation
// - coarse corrections while error above 15%, eight of them double or halve the period
// - one coarse doubling takes about 44 times N fast internal periods
// - each further doubling takes twice the time of the previous one
// - stable flag set once within 15%; clock then usable
// - after the window, minimum adjustments of 0.202% to 0.368% each
// - fine settling needs at most 88 corrections of four base periods
// - capacitor of 639 units, 384 fixed, 255 chosen by trim factor
// - trim factor resets to 80 hex, default capacitor 512 units
// - each added trim unit lowers base frequency about 0.195%
// - generator runs in wait; its interrupt can wake the processor
// - stop without run option halts generator, clock outputs held low
// - stop with run option keeps clocks; generator interrupts never wake from stop
// - stop without run option clears internal and external stable flags
// - stop without run option clears monitor enable, interrupt enable, fail flag
// - stop keeps source, clock enables, multiply, trim, divider and stage values
// - settling restarts after reset, multiply or trim change, clock re-enable
// - each correction lasts four base reference periods
module icst_top
    import icst_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic freq_too_slow,
    input wire logic freq_outside_window,
    input wire logic ext_clock_in,
    input wire logic monitor_inactive,
    input wire logic wait_mode,
    input wire logic stop_mode,
    output icst_clocks_type clocks,
    output icst_dco_type dco,
    output logic [9:0] cap_units,
    output logic [6:0] multiply_factor,
    output logic internal_clock_stable,
    output logic irq,
    output logic cpu_wake
);

    typedef struct packed {
        logic aw_full;
        logic w_full;
        logic [ADDR_W-1:0] waddr;
        logic [7:0] wbyte;
        logic wlane;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic internal_clock_on;
        logic external_clock_on;
        logic src_ext;
        logic clock_monitor_on;
        logic monitor_interrupt_enable;
        logic monitor_fail_flag;
        logic internal_clock_stable;
        logic external_clock_stable;
        logic run_clocks_in_stop;
        logic [6:0] mult;
        logic [7:0] trim;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        icst_lf_type lf;
        icst_dco_type dco;
        logic [9:0] base_cnt;
        logic [1:0] corr_cnt;
        logic [6:0] fine_cnt;
        logic [4:0] ext_cnt;
        logic restart;
        logic bus_phase;
        icst_clocks_type clocks;
        logic [9:0] cap;
        logic irq;
        logic wake;
    } icst_state_type;

    icst_state_type s;
    icst_state_type next_s;

    function automatic icst_dco_type dco_step(input icst_dco_type d, input logic shorten,
                                              input logic [11:0] step);
        logic [11:0] total;
        total = {d.divider, d.stage};
        if (shorten)
        begin
            total = (total < step) ? 12'h000 : total - step;
        end
        else
        begin
            total = (total > DCO_MAX - step) ? DCO_MAX : total + step;
        end
        return icst_dco_type'(total);
    endfunction

    function automatic logic [31:0] read_word(input icst_state_type r, input logic [ADDR_W-1:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            OFS_CONTROL:
            begin
                v[CTL_INTERNAL_CLOCK_OUT_ON] = r.internal_clock_on;
                v[CTL_ECLK_ON] = r.external_clock_on;
                v[CTL_SRC_EXT] = r.src_ext;
                v[CTL_MON_ON] = r.clock_monitor_on;
                v[CTL_MON_IE] = r.monitor_interrupt_enable;
                v[CTL_INTERNAL_CLOCK_OUT_STABLE] = r.internal_clock_stable;
                v[CTL_ECLK_STABLE] = r.external_clock_stable;
                v[CTL_MON_FAIL] = r.monitor_fail_flag;
            end
            OFS_MULT: v[6:0] = r.mult;
            OFS_TRIM: v[7:0] = r.trim;
            OFS_DCO: v[11:0] = r.dco;
            OFS_IRQ_STATUS: v[IRQ_W-1:0] = r.irq_status;
            OFS_IRQ_MASK: v[IRQ_W-1:0] = r.irq_mask;
            OFS_OPTION: v[OPT_RUN_IN_STOP] = r.run_clocks_in_stop;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == OFS_CONTROL || a == OFS_MULT || a == OFS_TRIM || a == OFS_DCO ||
               a == OFS_IRQ_STATUS || a == OFS_IRQ_MASK || a == OFS_OPTION;
    endfunction

    logic halted;
    logic gen_run;
    logic base_tick;
    logic [IRQ_W-1:0] events;
    logic [7:0] wb;

    always_comb
    begin
        next_s = s;
        events = '0;
        wb = s.wbyte;
        halted = stop_mode && !s.run_clocks_in_stop;
        gen_run = s.internal_clock_on && !halted;
        base_tick = !halted && (s.base_cnt == BASE_DIV_LAST);

        // write channel capture
        if (awvalid && s.awready)
        begin
            next_s.aw_full = 1'b1;
            next_s.waddr = awaddr;
        end
        if (wvalid && s.wready)
        begin
            next_s.w_full = 1'b1;
            next_s.wbyte = wdata[7:0];
            next_s.wlane = wstrb[0];
        end
        if (s.bvalid && bready)
        begin
            next_s.bvalid = 1'b0;
        end

        // register write once address and data are both held
        if (s.aw_full && s.w_full && !s.bvalid)
        begin
            next_s.aw_full = 1'b0;
            next_s.w_full = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = mapped(s.waddr) ? RESP_OKAY : RESP_SLVERR;
            if (s.wlane)
            begin
                case (s.waddr)
                    OFS_CONTROL:
                    begin
                        next_s.internal_clock_on = wb[CTL_INTERNAL_CLOCK_OUT_ON];
                        next_s.external_clock_on = wb[CTL_ECLK_ON];
                        next_s.src_ext = wb[CTL_SRC_EXT];
                        next_s.clock_monitor_on = wb[CTL_MON_ON];
                        next_s.monitor_interrupt_enable = wb[CTL_MON_IE] && wb[CTL_MON_ON];
                        if (wb[CTL_MON_FAIL] || !wb[CTL_MON_ON])
                        begin
                            next_s.monitor_fail_flag = 1'b0;
                        end
                    end
                    OFS_MULT:
                    begin
                        next_s.mult = wb[6:0];
                        next_s.restart = 1'b1;
                    end
                    OFS_TRIM:
                    begin
                        next_s.trim = wb;
                        next_s.restart = 1'b1;
                    end
                    OFS_IRQ_STATUS: next_s.irq_status = s.irq_status & ~wb[IRQ_W-1:0];
                    OFS_IRQ_MASK: next_s.irq_mask = wb[IRQ_W-1:0];
                    OFS_OPTION: next_s.run_clocks_in_stop = wb[OPT_RUN_IN_STOP];
                    default: next_s.bresp = RESP_SLVERR;
                endcase
            end
        end
        next_s.awready = !next_s.aw_full && !next_s.bvalid;
        next_s.wready = !next_s.w_full && !next_s.bvalid;

        // read channel
        if (s.rvalid && rready)
        begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && s.arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata = read_word(s, araddr);
            next_s.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        next_s.arready = !next_s.rvalid;

        // base reference divider
        if (!halted)
        begin
            next_s.base_cnt = base_tick ? 10'h000 : s.base_cnt + 10'h001;
        end

        // loop filter
        if (!gen_run)
        begin
            // divider and stage are kept while halted
            next_s.lf = LF_HALT;
            next_s.internal_clock_stable = 1'b0;
        end
        else if (s.lf == LF_HALT || s.restart)
        begin
            next_s.lf = LF_COARSE;
            next_s.restart = 1'b0;
            next_s.corr_cnt = 2'h0;
            next_s.fine_cnt = 7'h00;
            next_s.base_cnt = 10'h000;
            next_s.internal_clock_stable = 1'b0;
        end
        else if (base_tick)
        begin
            next_s.corr_cnt = s.corr_cnt + 2'h1;
            if (s.corr_cnt == CORR_TICKS_LAST)
            begin
                case (s.lf)
                    LF_COARSE:
                    begin
                        if (freq_outside_window)
                        begin
                            next_s.dco = dco_step(s.dco, freq_too_slow, COARSE_STEP);
                        end
                        else
                        begin
                            next_s.internal_clock_stable = 1'b1;
                            events[IRQ_STABLE] = 1'b1;
                            next_s.lf = LF_FINE;
                        end
                    end
                    LF_FINE:
                    begin
                        // fine settling limited to 88 corrections
                        if (s.fine_cnt == FINE_CORR_MAX)
                        begin
                            next_s.lf = LF_DONE;
                            events[IRQ_SETTLED] = 1'b1;
                        end
                        else
                        begin
                            next_s.dco = dco_step(s.dco, freq_too_slow, FINE_STEP);
                            next_s.fine_cnt = s.fine_cnt + 7'h01;
                        end
                    end
                    LF_DONE: next_s.dco = dco_step(s.dco, freq_too_slow, FINE_STEP);
                    default: next_s.lf = LF_COARSE;
                endcase
            end
        end

        // external stabilization divider
        if (!s.external_clock_on)
        begin
            next_s.external_clock_stable = 1'b0;
            next_s.ext_cnt = 5'h00;
        end
        else if (base_tick && !s.external_clock_stable)
        begin
            next_s.ext_cnt = s.ext_cnt + 5'h01;
            if (s.ext_cnt == EXT_STAB_LAST)
            begin
                next_s.external_clock_stable = 1'b1;
            end
        end

        // clock monitor, set wins over software clear
        if (monitor_inactive && s.clock_monitor_on)
        begin
            next_s.monitor_fail_flag = 1'b1;
            events[IRQ_MON_FAIL] = s.monitor_interrupt_enable;
        end

        if (halted)
        begin
            next_s.internal_clock_stable = 1'b0;
            next_s.external_clock_stable = 1'b0;
            next_s.ext_cnt = 5'h00;
            next_s.clock_monitor_on = 1'b0;
            next_s.monitor_interrupt_enable = 1'b0;
            next_s.monitor_fail_flag = 1'b0;
            events = '0;
        end

        // sticky status, set wins over clear
        next_s.irq_status = next_s.irq_status | events;
        next_s.irq = |(next_s.irq_status & next_s.irq_mask);
        // no wake from stop by generator interrupt
        next_s.wake = next_s.irq && wait_mode && !stop_mode;

        // clock outputs
        if (halted)
        begin
            next_s.clocks = '0;
            next_s.bus_phase = 1'b0;
        end
        else
        begin
            // clocks keep running when option set
            next_s.clocks.internal = s.internal_clock_on && !s.clocks.internal;
            if (s.internal_clock_on && s.clocks.internal)
            begin
                next_s.bus_phase = !s.bus_phase;
            end
            next_s.clocks.selected = s.src_ext ? ext_clock_in : next_s.clocks.internal;
            next_s.clocks.bus = s.src_ext ? ext_clock_in : next_s.bus_phase;
            next_s.clocks.timebase = next_s.clocks.selected;
        end

        // more units lower the base frequency
        next_s.cap = CAP_FIXED + {2'b00, next_s.trim};

        if (!aresetn)
        begin
            next_s = '0;
            next_s.awready = 1'b1;
            next_s.wready = 1'b1;
            next_s.arready = 1'b1;
            next_s.internal_clock_on = 1'b1;
            next_s.mult = MULT_RESET;
            next_s.trim = TRIM_RESET;
            next_s.cap = CAP_FIXED + {2'b00, TRIM_RESET};
            next_s.dco = icst_dco_type'(DCO_RESET);
            next_s.lf = LF_HALT;
        end
    end

    always_ff @(posedge aclk)
    begin
        s <= next_s;
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign clocks = s.clocks;
    assign dco = s.dco;
    assign cap_units = s.cap;
    assign multiply_factor = s.mult;
    assign internal_clock_stable = s.internal_clock_stable;
    assign irq = s.irq;
    assign cpu_wake = s.wake;

endmodule

// >>> verif/icst_assertions.sv
// checker of the clock settle block ports
// assumes binding into icst_top, one aclk domain
module icst_chk
    import icst_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire icst_clocks_type clocks,
    input wire icst_dco_type dco,
    input wire logic [9:0] cap_units,
    input wire logic [6:0] multiply_factor,
    input wire logic internal_clock_stable,
    input wire logic irq,
    input wire logic cpu_wake
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run_sh;
    logic [11:0] gap;
    logic [11:0] prev;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // shadow of run option and cycles since last correction
    always_ff @(posedge aclk)
    begin
        prev <= dco;
        if (!aresetn)
        begin
            run_sh <= 1'b0;
            gap <= 12'h000;
        end
        else
        begin
            if (awvalid && awready && wvalid && wready && wstrb[0] && awaddr == OFS_OPTION)
                run_sh <= wdata[OPT_RUN_IN_STOP];
            if (dco != prev)
                gap <= 12'h001;
            else if (gap != 12'hFFF)
                gap <= gap + 12'h001;
        end
    end
    a_wake_needs_wait: assert property (cpu_wake |->
        irq && $past(wait_mode) && !$past(stop_mode)) else $error("wake without wait");
    a_halt_clocks_low: assert property ((stop_mode && !run_sh)[*3] |-> clocks == 4'h0)
        else $error("clocks run while halted");
    a_halt_no_stable: assert property ((stop_mode && !run_sh)[*3] |-> !internal_clock_stable)
        else $error("stable kept while halted");
    a_halt_frozen: assert property ((stop_mode && !run_sh)[*4] |->
        $stable(dco) && $stable(cap_units) && $stable(multiply_factor)) else $error("settings moved in stop");
    a_cap_range: assert property (cap_units >= CAP_FIXED && cap_units <= 10'h27F)
        else $error("capacitor units out of range");
    a_coarse_step: assert property ($changed(dco) && !$past(internal_clock_stable) |->
        12'(dco - $past(dco)) == COARSE_STEP || 12'($past(dco) - dco) == COARSE_STEP
        || dco == DCO_MAX || dco == 12'h000) else $error("coarse step wrong");
    a_fine_step: assert property ($changed(dco) && $past(internal_clock_stable) && internal_clock_stable |->
        12'(dco - $past(dco)) == FINE_STEP || 12'($past(dco) - dco) == FINE_STEP) else $error("fine step wrong");
    a_corr_gap: assert property ($changed(dco) |-> gap >= 12'hBB8)
        else $error("corrections too close");
    c_stable: cover property ($rose(internal_clock_stable));
    c_wake: cover property (cpu_wake);
    c_halt: cover property ((stop_mode && !run_sh)[*3]);
endmodule
bind icst_top icst_chk u_chk (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .wait_mode, .stop_mode, .clocks, .dco, .cap_units, .multiply_factor, .internal_clock_stable, .irq, .cpu_wake);

// >>> verif/icst_plant.sv
// far side model: frequency comparator and bus clock consumer
// assumes dco from icst_top and a target setting from the bench
module icst_plant
    import icst_pkg::*;
(
    input wire logic aclk,
    input wire icst_dco_type dco,
    input wire logic [11:0] target,
    input wire icst_clocks_type clocks,
    output logic freq_too_slow,
    output logic freq_outside_window,
    output logic [15:0] bus_edges
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bus_q;
    initial
    begin
        freq_too_slow = 1'b0;
        freq_outside_window = 1'b1;
        bus_edges = 16'h0000;
        bus_q = 1'b0;
    end
    always @(posedge aclk)
    begin
        freq_outside_window <= dco > target + 12'h010 || target > dco + 12'h010;
        freq_too_slow <= dco > target;
        bus_q <= clocks.bus;
        if (clocks.bus && !bus_q)
            bus_edges <= bus_edges + 16'h0001;
    end
endmodule

// >>> verif/icst_tb_top.sv
// self-checking bench of the clock settle block
// assumes icst_top with the plant model as comparator
module icst_tb_top
    import icst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs, bs;
    logic freq_too_slow, freq_outside_window, wait_mode, stop_mode, internal_clock_stable, irq, cpu_wake;
    logic monitor_inactive;
    icst_clocks_type clocks;
    icst_dco_type dco;
    logic [9:0] cap_units;
    logic [6:0] multiply_factor;
    logic [11:0] target, d;
    logic [15:0] bus_edges, e;
    int num_errors, tests_run, cycles, n;
    icst_top u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .freq_too_slow,
        .freq_outside_window, .ext_clock_in(1'b0), .monitor_inactive, .wait_mode, .stop_mode, .clocks,
        .dco, .cap_units, .multiply_factor, .internal_clock_stable, .irq, .cpu_wake);
    icst_plant u_plant (.aclk, .dco, .target, .clocks, .freq_too_slow, .freq_outside_window, .bus_edges);
    always #2 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        tests_run++;
        if (got !== ex)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic done;
        done = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bready && bvalid)
            begin
                bs = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        @(posedge aclk);
    endtask
    task automatic rdr(input logic [7:0] a);
        logic done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rready && rvalid)
            begin
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        @(posedge aclk);
    endtask
    task automatic wait_dco();
        d = dco;
        n = 0;
        while (dco === d && n < 5000)
        begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic wait_stable(input int lim);
        n = 0;
        while (internal_clock_stable !== 1'b1 && n < lim)
        begin
            @(posedge aclk);
            n++;
        end
        chk("stable", 1, internal_clock_stable);
    endtask
    task automatic t_reset();
        rdr(OFS_CONTROL);
        chk("control", 32'h01, rd);
        rdr(OFS_MULT);
        chk("mult", 32'h15, rd);
        rdr(OFS_TRIM);
        chk("trim", 32'h80, rd);
        chk("cap", 10'h200, cap_units);
        rdr(8'h1C);
        chk("unmapped", {30'h0, RESP_SLVERR}, {rd[29:0], rs});
        wr(8'h1C, 32'h0);
        chk("wr unmapped", {30'h0, RESP_SLVERR}, {30'h0, bs});
    endtask
    task automatic t_coarse();
        wait_dco();
        chk("dco1", 12'h020, dco);
        wait_dco();
        chk("dco2", 12'h040, dco);
        chk("gap", 4 * BASE_DIV, n);
    endtask
    task automatic t_settle();
        wait_stable(8000);
        chk("dco3", 12'h060, dco);
        rdr(OFS_IRQ_STATUS);
        chk("status", 32'h1, rd & 32'h1);
        wait_dco();
        chk("fine", 12'h061, dco);
    endtask
    task automatic t_irq();
        wr(OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge aclk);
        chk("irq", 1, irq);
        wait_mode <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("wake", 1, cpu_wake);
        wr(OFS_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge aclk);
        chk("irq clr", 0, irq);
        wait_mode <= 1'b0;
    endtask
    task automatic t_trim();
        wr(OFS_TRIM, 32'h81);
        chk("trim resp", {30'h0, RESP_OKAY}, {30'h0, bs});
        repeat (2) @(posedge aclk);
        chk("cap trim", 10'h201, cap_units);
        chk("restart", 0, internal_clock_stable);
        rdr(OFS_TRIM);
        chk("trim rd", 32'h81, rd);
        wait_stable(7000);
    endtask
    task automatic t_stop();
        wr(OFS_OPTION, 32'h1);
        wait_mode <= 1'b1;
        stop_mode <= 1'b1;
        e = bus_edges;
        repeat (50) @(posedge aclk);
        chk("irq stop", 1, irq);
        chk("wake stop", 0, cpu_wake);
        chk("bus run", 1, bus_edges !== e);
        stop_mode <= 1'b0;
        wait_mode <= 1'b0;
        wr(OFS_CONTROL, 32'h1B);
        monitor_inactive <= 1'b1;
        @(posedge aclk);
        monitor_inactive <= 1'b0;
        rdr(OFS_CONTROL);
        chk("ctl fail", 32'hBB, rd);
        rdr(OFS_IRQ_STATUS);
        chk("mon status", 32'h4, rd & 32'h4);
        wr(OFS_OPTION, 32'h0);
        stop_mode <= 1'b1;
        repeat (8) @(posedge aclk);
        d = dco;
        chk("clocks", 4'h0, clocks);
        chk("no stable", 0, internal_clock_stable);
        rdr(OFS_CONTROL);
        chk("ctl stop", 32'h03, rd);
        chk("dco kept", d, dco);
        chk("mult kept", 7'h15, multiply_factor);
        stop_mode <= 1'b0;
        wait_stable(8000);
    endtask
    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, wait_mode, stop_mode, monitor_inactive} = 8'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        target = 12'h060;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_coarse();
        t_settle();
        t_irq();
        t_trim();
        t_stop();
        finish_test();
    end
endmodule
